// ===== core/cihc_consts.vh
// Constants for the interrupt and halt control block
`ifndef CIHC_CONSTS_VH
`define CIHC_CONSTS_VH
// APB register byte offsets
`define CIHC_CTRL_OFF     12'h000
`define CIHC_STATUS_OFF   12'h004
`define CIHC_VBASE_OFF    12'h008
`define CIHC_INSTR_OFF    12'h00C
`define CIHC_VECTOR_OFF   12'h010
`define CIHC_TARGET_OFF   12'h014
// Control register fields
`define CIHC_CTRL_MODE_LO 0
`define CIHC_CTRL_MODE_HI 1
`define CIHC_CTRL_RESET   2'h0
// Instruction codes written to the instruction register
`define CIHC_OP_NONE      3'h0
`define CIHC_OP_EI        3'h1
`define CIHC_OP_DI        3'h2
`define CIHC_OP_HALT      3'h3
`define CIHC_OP_RETURN_FROM_NMI_INSTR      3'h4
`define CIHC_OP_LDAI      3'h5
`define CIHC_OP_LDAR      3'h6
`define CIHC_OP_OTHER     3'h7
// Response modes
`define CIHC_MODE0        2'h0
`define CIHC_MODE1        2'h1
`define CIHC_MODE2        2'h2
// Fixed restart targets
`define CIHC_NMI_TARGET   16'h0066
`define CIHC_RST_TARGET   16'h0038
// Machine cycle lengths in T states
`define CIHC_FETCH_T      3'h4
`define CIHC_ACK_T        3'h6
`define CIHC_NMI_T        3'h5
`endif

// ===== core/cihc_core.v
// Interrupt acceptance, acknowledge, halt and enable flip-flop control
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cihc_consts.vh"
module cihc_core (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Request pins from peripherals, active low
  input  wire        int_request_n,
  input  wire        nmi_request_n,
  input  wire        bus_request_n,
  // Acknowledge side, data bus in
  input  wire [7:0]  data_bus_in,
  output reg         opcode_fetch_cycle_n,
  output reg         io_request_strobe_n,
  output reg         memory_request_strobe_n,
  output reg         halt_ack_n,
  output reg  [1:0]  t_state,
  output reg         wait_state,
  // Enable flip-flops and results
  output reg         irq_enable_primary,
  output reg         irq_enable_shadow,
  output reg         parity_flag,
  output reg         push_pc_pulse,
  output reg  [15:0] jump_target,
  output reg         exec_supplied_instr
);

  // Machine cycle states, one-hot
  localparam [4:0] ST_EXEC = 5'h01;
  localparam [4:0] ST_HALT = 5'h02;
  localparam [4:0] ST_IACK = 5'h04;
  localparam [4:0] ST_NACK = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg  [2:0]  tcount;
  reg  [1:0]  mode;
  reg  [7:0]  vector_base;
  reg  [7:0]  vector;
  reg  [2:0]  pend_op;
  reg         op_valid;
  reg         ei_delay;
  reg  [1:0]  int_sync;
  reg  [1:0]  nmi_sync;
  reg  [1:0]  busrq_sync;
  reg  [1:0]  ack_kind;

  // Synchronised request levels, active high
  wire int_req   = ~int_sync[1];
  wire nmi_req   = ~nmi_sync[1];
  wire busrq     = ~busrq_sync[1];

  // Decodes last T state of current machine cycle
  function last_t;
    input [2:0] cnt;
    input [2:0] len;
    begin
      last_t = (cnt == len - 3'h1);
    end
  endfunction

  wire apb_wr = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Instruction boundary: end of an execute cycle or a halt fetch
  wire fetch_end = (state == ST_EXEC || state == ST_HALT) && last_t(tcount, `CIHC_FETCH_T);
  // refuse when disabled or bus requested
  wire int_take  = fetch_end & int_req & irq_enable_primary & ~busrq & ~ei_delay & ~nmi_req;
  wire nmi_take  = fetch_end & nmi_req;

  // Request pin synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sync   <= 2'h3;
      nmi_sync   <= 2'h3;
      busrq_sync <= 2'h3;
    end else begin
      int_sync   <= {int_sync[0], int_request_n};
      nmi_sync   <= {nmi_sync[0], nmi_request_n};
      busrq_sync <= {busrq_sync[0], bus_request_n};
    end
  end

  // Next machine cycle selection
  always @* begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        if (nmi_take)
          next_state = ST_NACK;
        else if (int_take)
          next_state = ST_IACK;
        else if (fetch_end && op_valid && pend_op == `CIHC_OP_HALT)
          next_state = ST_HALT;
      end
      ST_HALT: begin
        if (nmi_take)
          next_state = ST_NACK;
        else if (int_take)
          next_state = ST_IACK;
      end
      ST_IACK: begin
        if (last_t(tcount, `CIHC_ACK_T))
          next_state = ST_DONE;
      end
      ST_NACK: begin
        if (last_t(tcount, `CIHC_NMI_T))
          next_state = ST_DONE;
      end
      ST_DONE: next_state = ST_EXEC;
      default: next_state = ST_EXEC;
    endcase
  end

  // all state held in flip-flops; a stopped pclk freezes it
  // resumes from same state when pclk returns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= ST_EXEC;
      tcount <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state || fetch_end)
        tcount <= 3'h0;
      else
        tcount <= tcount + 3'h1;
    end
  end

  // Bus strobes and status outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_fetch_cycle_n    <= 1'b1;
      io_request_strobe_n     <= 1'b1;
      memory_request_strobe_n <= 1'b1;
      halt_ack_n              <= 1'b1;
      t_state                 <= 2'h0;
      wait_state              <= 1'b0;
    end else begin
      t_state <= tcount[1:0];
      halt_ack_n <= ~(next_state == ST_HALT);
      // acknowledge fetch uses I/O strobe, not memory strobe
      // halt keeps issuing ordinary fetches for refresh
      opcode_fetch_cycle_n    <= ~(next_state == ST_IACK || next_state == ST_HALT || next_state == ST_EXEC);
      io_request_strobe_n     <= ~(state == ST_IACK && next_state == ST_IACK && tcount >= 3'h2);
      memory_request_strobe_n <= ~(next_state == ST_HALT || next_state == ST_EXEC || next_state == ST_NACK);
      // same wait states in mode 1
      wait_state <= (next_state == ST_IACK) && (tcount == 3'h1 || tcount == 3'h2);
    end
  end

  // Vector capture, targets and push pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector              <= 8'h00;
      jump_target         <= 16'h0000;
      push_pc_pulse       <= 1'b0;
      exec_supplied_instr <= 1'b0;
      ack_kind            <= 2'h0;
    end else begin
      push_pc_pulse       <= 1'b0;
      exec_supplied_instr <= 1'b0;
      if (state == ST_IACK && last_t(tcount, `CIHC_ACK_T)) begin
        vector   <= data_bus_in;
        ack_kind <= mode;
        case (mode)
          `CIHC_MODE0: exec_supplied_instr <= 1'b1;
          `CIHC_MODE1: begin
            jump_target   <= `CIHC_RST_TARGET;
            push_pc_pulse <= 1'b1;
          end
          // table pointer from base and vector
          default: begin
            jump_target   <= {vector_base, data_bus_in};
            push_pc_pulse <= 1'b1;
          end
        endcase
      end else if (state == ST_NACK && last_t(tcount, `CIHC_NMI_T)) begin
        // bus data discarded, push and restart
        jump_target   <= `CIHC_NMI_TARGET;
        push_pc_pulse <= 1'b1;
        ack_kind      <= 2'h3;
      end
    end
  end

  // Enable flip-flops and instruction side effects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_primary <= 1'b0;
      irq_enable_shadow  <= 1'b0;
      parity_flag        <= 1'b0;
      ei_delay           <= 1'b0;
    end else begin
      if (fetch_end && state == ST_EXEC)
        ei_delay <= 1'b0;
      if (int_take) begin
        irq_enable_primary <= 1'b0;
        irq_enable_shadow  <= 1'b0;
      end else if (nmi_take) begin
        irq_enable_primary <= 1'b0;
      end else if (fetch_end && state == ST_EXEC && op_valid) begin
        case (pend_op)
          `CIHC_OP_EI: begin
            irq_enable_primary <= 1'b1;
            irq_enable_shadow  <= 1'b1;
            ei_delay           <= 1'b1;
          end
          `CIHC_OP_DI: begin
            irq_enable_primary <= 1'b0;
            irq_enable_shadow  <= 1'b0;
          end
          `CIHC_OP_RETURN_FROM_NMI_INSTR: irq_enable_primary <= irq_enable_shadow;
          `CIHC_OP_LDAI, `CIHC_OP_LDAR: parity_flag <= irq_enable_shadow;
          default: parity_flag <= parity_flag;
        endcase
      end
    end
  end

  // Software instruction slot, consumed at instruction end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_op     <= `CIHC_OP_NONE;
      op_valid    <= 1'b0;
      mode        <= `CIHC_CTRL_RESET;
      vector_base <= 8'h00;
    end else begin
      if (fetch_end && state == ST_EXEC && !nmi_take && !int_take)
        op_valid <= 1'b0;
      if (apb_wr && !psel_busy(paddr)) begin
        case (paddr)
          `CIHC_CTRL_OFF:  mode <= pwdata[`CIHC_CTRL_MODE_HI:`CIHC_CTRL_MODE_LO];
          `CIHC_VBASE_OFF: vector_base <= pwdata[7:0];
          `CIHC_INSTR_OFF: begin
            pend_op  <= pwdata[2:0];
            op_valid <= 1'b1;
          end
          default: mode <= mode;
        endcase
      end
    end
  end

  // Instruction writes are accepted in any state
  function psel_busy;
    input [11:0] a;
    begin
      psel_busy = 1'b0;
    end
  endfunction

  // Register read mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CIHC_CTRL_OFF:   prdata <= {30'h0, mode};
        `CIHC_STATUS_OFF: prdata <= {22'h0, ack_kind, ei_delay, op_valid, parity_flag,
                                     irq_enable_shadow, irq_enable_primary, ~halt_ack_n, state == ST_IACK,
                                     state == ST_NACK};
        `CIHC_VBASE_OFF:  prdata <= {24'h0, vector_base};
        `CIHC_INSTR_OFF:  prdata <= {29'h0, pend_op};
        `CIHC_VECTOR_OFF: prdata <= {24'h0, vector};
        `CIHC_TARGET_OFF: prdata <= {16'h0, jump_target};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // cihc_core

// ===== test/cihc_periph.sv
// Interrupting peripheral model: request lines and acknowledge vector
`timescale 1ns/1ps
module cihc_periph (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Bench commands
  input  wire       raise_int,
  input  wire       raise_nmi,
  input  wire [7:0] vector,
  // Device side
  input  wire       opcode_fetch_cycle_n,
  input  wire       io_request_strobe_n,
  input  wire       push_pc_pulse,
  output reg        int_request_n,
  output reg        nmi_request_n,
  output reg  [7:0] data_bus_in
);
  reg [7:0] last_bus = 8'h5A;
  // Requests stay low until the device acknowledges them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_request_n <= 1'b1;
      nmi_request_n <= 1'b1;
    end else begin
      if (raise_int) int_request_n <= 1'b0;
      else if (!io_request_strobe_n) int_request_n <= 1'b1;
      if (raise_nmi) nmi_request_n <= 1'b0;
      else if (push_pc_pulse) nmi_request_n <= 1'b1;
    end
  end
  always @* begin
    if (!io_request_strobe_n && !opcode_fetch_cycle_n) data_bus_in = vector;
    else data_bus_in = ~last_bus;
  end
  always @(posedge pclk) last_bus <= data_bus_in;
endmodule // cihc_periph

// ===== test/cihc_props.sv
// Assertion checker for the interrupt and halt control block
`timescale 1ns/1ps
module cihc_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Observed outputs
  input wire opcode_fetch_cycle_n,
  input wire io_request_strobe_n,
  input wire halt_ack_n,
  input wire wait_state,
  input wire irq_enable_primary,
  input wire irq_enable_shadow,
  input wire parity_flag,
  input wire push_pc_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Acknowledge and enable relations
  property p_ack_fetch;
    $fell(io_request_strobe_n) |-> !opcode_fetch_cycle_n;
  endproperty
  a_ack_fetch: assert property (p_ack_fetch) else $error("ack strobe outside fetch");
  property p_two_waits;
    $rose(wait_state) |=> wait_state ##1 !wait_state;
  endproperty
  a_two_waits: assert property (p_two_waits) else $error("wait count wrong");
  property p_ack_clear;
    $fell(io_request_strobe_n) |-> ##[0:6] (!irq_enable_primary && !irq_enable_shadow);
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("enables not cleared");
  property p_halt_hold;
    !halt_ack_n |-> !push_pc_pulse;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("push while halted");
  property p_set_both;
    $rose(irq_enable_primary) |-> irq_enable_shadow;
  endproperty
  a_set_both: assert property (p_set_both) else $error("primary set alone");
  property p_shadow_kept;
    $fell(irq_enable_shadow) |-> !irq_enable_primary;
  endproperty
  a_shadow_kept: assert property (p_shadow_kept) else $error("shadow cleared alone");
  property p_halt_exit;
    $rose(halt_ack_n) |-> ##[0:10] (!io_request_strobe_n || push_pc_pulse);
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("no ack after halt");
  property p_parity_copy;
    $changed(parity_flag) |-> parity_flag == irq_enable_shadow;
  endproperty
  a_parity_copy: assert property (p_parity_copy) else $error("parity not shadow");
endmodule // cihc_props
bind cihc_core cihc_props u_props (.pclk(pclk), .presetn(presetn),
  .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .io_request_strobe_n(io_request_strobe_n),
  .halt_ack_n(halt_ack_n), .wait_state(wait_state), .irq_enable_primary(irq_enable_primary),
  .irq_enable_shadow(irq_enable_shadow), .parity_flag(parity_flag), .push_pc_pulse(push_pc_pulse));

// ===== test/tb_top.sv
// Testbench for the interrupt and halt control block
`timescale 1ns/1ps
`include "cihc_consts.vh"
module tb_top;
  reg         pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg         bus_request_n = 1'b1, raise_int = 1'b0, raise_nmi = 1'b0;
  reg  [7:0]  vector = 8'h00;
  reg  [15:0] last_jt = 16'h0000;
  wire [31:0] prdata;
  wire [15:0] jump_target;
  wire [7:0]  data_bus_in;
  wire [1:0]  t_state;
  wire        pready, pslverr, int_request_n, nmi_request_n, opcode_fetch_cycle_n, io_request_strobe_n;
  wire        memory_request_strobe_n, halt_ack_n, wait_state, irq_enable_primary, irq_enable_shadow;
  wire        parity_flag, push_pc_pulse, exec_supplied_instr;
  integer     failures = 0, samples_checked = 0, n_wait = 0, n_push = 0, n_exec = 0, p;
  cihc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_request_n(int_request_n), .nmi_request_n(nmi_request_n), .bus_request_n(bus_request_n),
    .data_bus_in(data_bus_in), .opcode_fetch_cycle_n(opcode_fetch_cycle_n),
    .io_request_strobe_n(io_request_strobe_n), .memory_request_strobe_n(memory_request_strobe_n),
    .halt_ack_n(halt_ack_n), .t_state(t_state), .wait_state(wait_state),
    .irq_enable_primary(irq_enable_primary), .irq_enable_shadow(irq_enable_shadow),
    .parity_flag(parity_flag), .push_pc_pulse(push_pc_pulse), .jump_target(jump_target),
    .exec_supplied_instr(exec_supplied_instr));
  cihc_periph u_periph (.pclk(pclk), .presetn(presetn), .raise_int(raise_int), .raise_nmi(raise_nmi),
    .vector(vector), .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .io_request_strobe_n(io_request_strobe_n),
    .push_pc_pulse(push_pc_pulse), .int_request_n(int_request_n), .nmi_request_n(nmi_request_n),
    .data_bus_in(data_bus_in));
  // Clock generation
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Counts wait states, pushes and supplied-instruction runs
  always @(posedge pclk) begin
    if (wait_state === 1'b1) n_wait <= n_wait + 1;
    if (exec_supplied_instr === 1'b1) n_exec <= n_exec + 1;
    if (push_pc_pulse === 1'b1) begin
      n_push <= n_push + 1;
      last_jt <= jump_target;
    end
  end
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) failures = failures + 1;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Instruction code, then room for it to execute
  task op(input reg [2:0] c);
    begin
      apb(1'b1, `CIHC_INSTR_OFF, {29'h0, c});
      cyc(12);
    end
  endtask
  // Raise requests, optionally held off first, then wait for the response
  task fire(input reg i, input reg m, input reg [7:0] v, input reg e);
    integer n, base, w0;
    begin
      base = n_push + n_exec;
      w0 = n_wait;
      vector <= v;
      raise_int <= i;
      raise_nmi <= m;
      if (e) bus_request_n <= 1'b0;
      @(posedge pclk);
      raise_int <= 1'b0;
      raise_nmi <= 1'b0;
      if (e) begin
        cyc(20);
        chk(n_wait, w0);
        op(3'h1);
        bus_request_n <= 1'b1;
      end
      n = 0;
      while (n_push + n_exec == base && n < 200) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 200) failures = failures + 1;
      cyc(4);
    end
  endtask
  task results;
    begin
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #3000000;
    failures = failures + 1;
    results;
  end
  // Main sequence
  initial begin
    cyc(5);
    presetn <= 1'b1;
    chk(irq_enable_primary, 0);
    chk(irq_enable_shadow, 0);
    apb(1'b0, `CIHC_CTRL_OFF, 0);
    chk(rd, 0);
    apb(1'b0, `CIHC_VBASE_OFF, 0);
    chk(rd, 0);
    apb(1'b0, 12'hFF0, 0);
    chk(rd, 0);
    bus_request_n <= 1'b0;
    op(3'h1);
    chk({irq_enable_primary, irq_enable_shadow}, 3);
    fire(1'b1, 1'b0, 8'h11, 1'b1);
    chk(n_exec, 1);
    chk(n_wait, 2);
    chk({irq_enable_primary, irq_enable_shadow}, 0);
    apb(1'b0, `CIHC_VECTOR_OFF, 0);
    chk(rd, 32'h11);
    apb(1'b1, `CIHC_CTRL_OFF, 1);
    fire(1'b1, 1'b0, 8'h55, 1'b1);
    chk(last_jt, `CIHC_RST_TARGET);
    chk(n_wait, 4);
    apb(1'b1, `CIHC_VBASE_OFF, 32'h3C);
    apb(1'b1, `CIHC_CTRL_OFF, 2);
    fire(1'b1, 1'b0, 8'hA4, 1'b1);
    chk(last_jt, 16'h3CA4);
    op(3'h1);
    op(3'h2);
    chk({irq_enable_primary, irq_enable_shadow}, 0);
    op(3'h1);
    fire(1'b0, 1'b1, 8'h00, 1'b0);
    chk(last_jt, `CIHC_NMI_TARGET);
    chk({irq_enable_primary, irq_enable_shadow}, 1);
    op(3'h5);
    chk(parity_flag, 1);
    op(3'h4);
    chk(irq_enable_primary, 1);
    op(3'h2);
    op(3'h6);
    chk(parity_flag, 0);
    p = n_push;
    fire(1'b0, 1'b1, 8'h00, 1'b0);
    chk(n_push, p + 1);
    op(3'h1);
    op(3'h3);
    p = n_push;
    cyc(20);
    chk(n_push, p);
    chk(halt_ack_n, 0);
    chk(memory_request_strobe_n, 0);
    chk(opcode_fetch_cycle_n, 0);
    chk(pslverr, 0);
    fire(1'b1, 1'b1, 8'h22, 1'b0);
    chk(last_jt, `CIHC_NMI_TARGET);
    chk(halt_ack_n, 1);
    results;
  end
endmodule // tb_top
